// file: hdl/txfe_extractor.v
// transmit buffer frame extractor: read side of the transmit fifo.
// assumes a show-ahead fifo: word on fifo_data_in while fifo_valid_in,
// advanced by one registered pop pulse. one clock, synchronous reset.
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "txfe_regs.vh"

// Contract
// - checksum only when request bit, first segment and engine enable all set
// - crc suppress bit set means no automatic crc
// - padding suppress stops padding short frames; otherwise pad below 64
// - padding suppress forces crc regardless of crc suppress
// - 11-bit frame length is total frame bytes without offset or padding
// - byte count differing from frame length sets the transmit error flag
// - frame length decides how many bytes move to transmit interface
// - final word byte enables mask trailing bytes
// - payload starts at third word after the two command words
// - start offset picks first byte lane: 0 low byte to 3 top byte
// - unused trailing bytes of a buffer are discarded
// - any start and end alignment accepted, also across buffers
// - buffer consistency error means lost sync; reinit before accepting frames
// - both command words stripped, never forwarded
// - size and offset give unused bytes in first and last words
// - read side never rewinds
// - second command word same across frame except checksum bit; else error
// - first command word bit 13 first segment, bit 12 last segment
// - first command word bits 17:16 give start offset 0..3
// - first command word bits 10:0 give buffer payload size
module txfe_extractor #(
  parameter ADDR_W = 4
) (
  input wire clock_in,
  input wire rst_in,
  // register port
  input wire [ADDR_W-1:0] bus_addr_in,
  input wire [31:0] bus_wdata_in,
  input wire bus_write_in,
  input wire bus_read_in,
  output reg [31:0] bus_rdata_out,
  // transmit fifo read side
  input wire [31:0] fifo_data_in,
  input wire fifo_valid_in,
  output reg fifo_pop_out,
  // transmit interface
  output wire mac_valid_out,
  output wire [31:0] mac_data_out,
  output wire [3:0] mac_be_out,
  output wire mac_last_out,
  input wire mac_ready_in,
  output reg mac_csum_out,
  output reg mac_no_crc_out,
  output reg mac_no_pad_out,
  // sticky transmit error, also readable as bit 0 of the status register
  output reg transmit_error_flag_out
);
  localparam [3:0] S_CMDA = 4'b0001;
  localparam [3:0] S_CMDB = 4'b0010;
  localparam [3:0] S_DATA = 4'b0100;
  localparam [3:0] S_HALT = 4'b1000;

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [31:0] cmda_reg;
  reg [31:0] cmdb_reg;
  reg in_frame_reg;
  reg [10:0] used_reg;
  reg [10:0] buf_rem_reg;
  reg [1:0] lane_reg;
  reg checksum_engine_on_reg;
  reg [15:0] frames_reg;

  wire first_segment_flag;
  wire last_segment_flag;
  wire [1:0] first_byte_position;
  wire [10:0] buf_size;
  wire [10:0] frame_len;
  wire [11:0] used_after;
  wire cmdb_mismatch;
  wire err_missing_first;
  wire err_unexp_first;
  wire err_unexp_last;
  wire err_missing_last;
  wire err_size_zero;
  wire err_size;
  wire buf_error;
  wire pk_ready;
  wire take;
  wire [2:0] avail;
  wire [2:0] nbytes;
  wire word_ends_buf;
  wire [31:0] picked;

  assign first_segment_flag = cmda_reg[`TXFE_A_FIRST_BIT];
  assign last_segment_flag = cmda_reg[`TXFE_A_LAST_BIT];
  assign first_byte_position = cmda_reg[`TXFE_A_OFF_HI:`TXFE_A_OFF_LO];
  assign buf_size = cmda_reg[`TXFE_A_SIZE_HI:0];

  // a frame's length comes from its opening buffer; later copies must match
  assign frame_len = in_frame_reg ? cmdb_reg[`TXFE_B_FLEN_HI:0] :
                     fifo_data_in[`TXFE_B_FLEN_HI:0];
  assign used_after = (in_frame_reg ? {1'b0, used_reg} : 12'h0) + {1'b0, buf_size};

  // checksum bit excluded from the comparison
  assign cmdb_mismatch = in_frame_reg &&
    ((fifo_data_in[31:15] != cmdb_reg[31:15]) ||
     (fifo_data_in[13:0] != cmdb_reg[13:0]));
  assign err_missing_first = ~in_frame_reg & ~first_segment_flag;
  assign err_unexp_first = in_frame_reg & first_segment_flag;
  assign err_unexp_last = last_segment_flag && (used_after < {1'b0, frame_len});
  assign err_missing_last = ~last_segment_flag && (used_after >= {1'b0, frame_len});
  assign err_size_zero = (buf_size == 11'h0);
  assign err_size = used_after > {1'b0, frame_len};
  assign buf_error = cmdb_mismatch | err_missing_first | err_unexp_first |
                     err_unexp_last | err_missing_last | err_size_zero | err_size;

  // one word per two cycles: the registered pop needs a cycle to advance the fifo
  assign take = fifo_valid_in & ~fifo_pop_out &
                ((state_reg == S_CMDA) | (state_reg == S_CMDB) |
                 ((state_reg == S_DATA) & pk_ready));

  // bytes carried by this payload word, bounded by what the buffer still holds
  assign avail = 3'd4 - {1'b0, lane_reg};
  assign word_ends_buf = buf_rem_reg <= {8'h0, avail};
  assign nbytes = word_ends_buf ? buf_rem_reg[2:0] : avail;

  txfe_lane_pick u_pick (
    .word_in(fifo_data_in),
    .lane_in(lane_reg),
    .count_in(nbytes),
    .data_out(picked)
  );

  // only payload words reach the packer, command words never do
  txfe_packer u_pack (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .in_valid_in(take && (state_reg == S_DATA)),
    .in_data_in(picked),
    .in_count_in(nbytes),
    .in_last_in(word_ends_buf && last_segment_flag),
    .in_ready_out(pk_ready),
    .out_valid_out(mac_valid_out),
    .out_data_out(mac_data_out),
    .out_be_out(mac_be_out),
    .out_last_out(mac_last_out),
    .out_ready_in(mac_ready_in)
  );

  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_CMDA: begin
        if (take)
          state_next = S_CMDB;
      end
      S_CMDB: begin
        if (take)
          state_next = buf_error ? S_HALT : S_DATA;
      end
      S_DATA: begin
        if (take && word_ends_buf)
          state_next = S_CMDA;
      end
      S_HALT: state_next = S_HALT;
      default: state_next = S_HALT;
    endcase
  end

  // frame sequencing; no rewind path on this side
  always @(posedge clock_in) begin
    if (rst_in) begin
      state_reg <= S_CMDA;
      cmda_reg <= 32'h0;
      cmdb_reg <= 32'h0;
      in_frame_reg <= 1'b0;
      used_reg <= 11'h0;
      buf_rem_reg <= 11'h0;
      lane_reg <= 2'h0;
      fifo_pop_out <= 1'b0;
      frames_reg <= 16'h0;
      transmit_error_flag_out <= 1'b0;
      mac_csum_out <= 1'b0;
      mac_no_crc_out <= 1'b0;
      mac_no_pad_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      fifo_pop_out <= take;
      if (take && (state_reg == S_CMDA))
        cmda_reg <= fifo_data_in;
      if (take && (state_reg == S_CMDB)) begin
        if (buf_error) begin
          transmit_error_flag_out <= 1'b1;
        end else begin
          buf_rem_reg <= buf_size;
          lane_reg <= first_byte_position;
          used_reg <= used_after[10:0];
          in_frame_reg <= ~last_segment_flag;
          if (!in_frame_reg) begin
            cmdb_reg <= fifo_data_in;
            mac_csum_out <= fifo_data_in[`TXFE_B_CSUM_BIT] & first_segment_flag &
                            checksum_engine_on_reg;
            mac_no_pad_out <= fifo_data_in[`TXFE_B_NOPAD_BIT];
            mac_no_crc_out <= fifo_data_in[`TXFE_B_NOCRC_BIT] &
                              ~fifo_data_in[`TXFE_B_NOPAD_BIT];
          end
        end
      end
      if (take && (state_reg == S_DATA)) begin
        buf_rem_reg <= buf_rem_reg - {8'h0, nbytes};
        lane_reg <= 2'h0;
        if (word_ends_buf && last_segment_flag)
          frames_reg <= frames_reg + 16'h1;
      end
    end
  end

  // register port: read data stand in the cycle after the strobe
  always @(posedge clock_in) begin
    if (rst_in) begin
      checksum_engine_on_reg <= `TXFE_CTRL_RESET;
      bus_rdata_out <= 32'h0;
    end else begin
      if (bus_write_in && (bus_addr_in == `TXFE_ADDR_CTRL))
        checksum_engine_on_reg <= bus_wdata_in[`TXFE_CTRL_CSUM_BIT];
      bus_rdata_out <= 32'h0;
      if (bus_read_in) begin
        case (bus_addr_in)
          `TXFE_ADDR_CTRL: bus_rdata_out <= {31'h0, checksum_engine_on_reg};
          `TXFE_ADDR_STAT: bus_rdata_out <= {frames_reg, 14'h0,
                                             state_reg == S_HALT,
                                             transmit_error_flag_out};
          default: bus_rdata_out <= 32'h0;
        endcase
      end
    end
  end
endmodule

`default_nettype wire

// file: pkg/txfe_regs.vh
// constants for the transmit buffer frame extractor: command word fields,
// register offsets, reset values. included by the extractor design file by bare name.
`ifndef TXFE_REGS_VH
`define TXFE_REGS_VH

// first command word
`define TXFE_A_OFF_HI 17
`define TXFE_A_OFF_LO 16
`define TXFE_A_FIRST_BIT 13
`define TXFE_A_LAST_BIT 12
`define TXFE_A_SIZE_HI 10

// second command word
`define TXFE_B_CSUM_BIT 14
`define TXFE_B_NOCRC_BIT 13
`define TXFE_B_NOPAD_BIT 12
`define TXFE_B_FLEN_HI 10

// register map (byte addresses)
`define TXFE_ADDR_CTRL 4'h0
`define TXFE_ADDR_STAT 4'h4
`define TXFE_CTRL_CSUM_BIT 0
`define TXFE_CTRL_RESET 1'b0
`define TXFE_STAT_ERR_BIT 0
`define TXFE_STAT_HALT_BIT 1

`endif

// file: hdl/txfe_lane_pick.v
// lane picker: moves the valid bytes of one payload word down to lane 0
// and zeroes every byte past the count. purely combinational.
`timescale 1ns/10ps
`default_nettype none

module txfe_lane_pick (
  input wire [31:0] word_in,
  input wire [1:0] lane_in,
  input wire [2:0] count_in,
  output reg [31:0] data_out
);
  reg [31:0] shifted;
  always @* begin
    shifted = word_in >> {lane_in, 3'b000};
    case (count_in)
      3'd1: data_out = shifted & 32'h0000_00ff;
      3'd2: data_out = shifted & 32'h0000_ffff;
      3'd3: data_out = shifted & 32'h00ff_ffff;
      default: data_out = shifted;
    endcase
  end
endmodule

`default_nettype wire

// file: hdl/txfe_packer.v
// byte packer: gathers 1..4 byte pieces into whole words for the transmit
// interface, with byte enables on the closing word of a frame.
// assumes pieces arrive low-aligned with unused upper bytes zero.
`timescale 1ns/10ps
`default_nettype none

module txfe_packer (
  input wire clock_in,
  input wire rst_in,
  input wire in_valid_in,
  input wire [31:0] in_data_in,
  input wire [2:0] in_count_in,
  input wire in_last_in,
  output wire in_ready_out,
  output reg out_valid_out,
  output reg [31:0] out_data_out,
  output reg [3:0] out_be_out,
  output reg out_last_out,
  input wire out_ready_in
);
  reg [23:0] hold_reg;
  reg [1:0] hcnt_reg;
  reg tail_reg;
  wire slot_free;
  wire [55:0] comb;
  wire [2:0] total;

  assign slot_free = ~out_valid_out | out_ready_in;
  // a trailing word still owed for the previous frame blocks new input
  assign in_ready_out = slot_free & ~tail_reg;
  assign comb = {24'h0, in_data_in} << {hcnt_reg, 3'b000} | {32'h0, hold_reg};
  assign total = {1'b0, hcnt_reg} + in_count_in;

  function [3:0] be_of;
    input [2:0] n;
    begin
      case (n)
        3'd1: be_of = 4'h1;
        3'd2: be_of = 4'h3;
        3'd3: be_of = 4'h7;
        default: be_of = 4'hf;
      endcase
    end
  endfunction

  always @(posedge clock_in) begin
    if (rst_in) begin
      hold_reg <= 24'h0;
      hcnt_reg <= 2'h0;
      tail_reg <= 1'b0;
      out_valid_out <= 1'b0;
      out_data_out <= 32'h0;
      out_be_out <= 4'h0;
      out_last_out <= 1'b0;
    end else begin
      if (out_valid_out && out_ready_in)
        out_valid_out <= 1'b0;
      if (slot_free && tail_reg) begin
        out_valid_out <= 1'b1;
        out_data_out <= {8'h0, hold_reg};
        out_be_out <= be_of({1'b0, hcnt_reg});
        out_last_out <= 1'b1;
        hold_reg <= 24'h0;
        hcnt_reg <= 2'h0;
        tail_reg <= 1'b0;
      end else if (in_valid_in && in_ready_out) begin
        if (in_last_in || total[2]) begin
          out_valid_out <= 1'b1;
          out_data_out <= comb[31:0];
          out_be_out <= total[2] ? 4'hf : be_of(total);
          out_last_out <= in_last_in && (total <= 3'd4);
        end
        if (total[2]) begin
          hold_reg <= comb[55:32];
          hcnt_reg <= total[1:0];
          tail_reg <= in_last_in && (total != 3'd4);
        end else if (in_last_in) begin
          hold_reg <= 24'h0;
          hcnt_reg <= 2'h0;
        end else begin
          hold_reg <= comb[23:0];
          hcnt_reg <= total[1:0];
        end
      end
    end
  end
endmodule

`default_nettype wire

// file: tb/txfe_extractor_monitor.sv
// port assertions for the frame extractor
// assumes one clock and a synchronous reset
`timescale 1ns/10ps
`default_nettype none
module txfe_extractor_monitor (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [3:0] bus_addr_in,
  input wire logic bus_read_in,
  input wire logic [31:0] bus_rdata_out,
  input wire logic fifo_pop_out,
  input wire logic mac_valid_out,
  input wire logic [31:0] mac_data_out,
  input wire logic [3:0] mac_be_out,
  input wire logic mac_last_out,
  input wire logic mac_ready_in,
  input wire logic mac_no_crc_out,
  input wire logic mac_no_pad_out,
  input wire logic transmit_error_flag_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence s_stall;
    mac_valid_out && !mac_ready_in;
  endsequence
  sequence s_held;
    mac_valid_out && $stable(mac_data_out) && $stable(mac_be_out) && $stable(mac_last_out);
  endsequence
  property p_sticky;
    transmit_error_flag_out |=> transmit_error_flag_out;
  endproperty
  property p_halt;
    $past(transmit_error_flag_out) |-> !fifo_pop_out;
  endproperty
  property p_be_legal;
    mac_valid_out |-> mac_be_out inside {4'h1, 4'h3, 4'h7, 4'hf};
  endproperty
  property p_be_last;
    mac_valid_out && mac_be_out != 4'hf |-> mac_last_out;
  endproperty
  property p_hold;
    s_stall |=> s_held;
  endproperty
  property p_pop_gap;
    fifo_pop_out |=> !fifo_pop_out;
  endproperty
  property p_crc_pad;
    mac_no_pad_out |-> !mac_no_crc_out;
  endproperty
  property p_err_read;
    bus_read_in && bus_addr_in == 4'h4 |=> bus_rdata_out[0] == $past(transmit_error_flag_out);
  endproperty
  a_sticky: assert property (p_sticky) else $error("error flag dropped");
  a_halt: assert property (p_halt) else $error("pop after error");
  a_be_legal: assert property (p_be_legal) else $error("bad byte enables");
  a_be_last: assert property (p_be_last) else $error("partial word not last");
  a_hold: assert property (p_hold) else $error("word changed while stalled");
  a_pop_gap: assert property (p_pop_gap) else $error("pop too long");
  a_crc_pad: assert property (p_crc_pad) else $error("crc dropped with no pad");
  a_err_read: assert property (p_err_read) else $error("status error bit wrong");
endmodule
bind txfe_extractor txfe_extractor_monitor u_txfe_extractor_monitor (
  .clock_in(clock_in), .rst_in(rst_in), .bus_addr_in(bus_addr_in),
  .bus_read_in(bus_read_in), .bus_rdata_out(bus_rdata_out), .fifo_pop_out(fifo_pop_out),
  .mac_valid_out(mac_valid_out), .mac_data_out(mac_data_out), .mac_be_out(mac_be_out),
  .mac_last_out(mac_last_out), .mac_ready_in(mac_ready_in), .mac_no_crc_out(mac_no_crc_out),
  .mac_no_pad_out(mac_no_pad_out), .transmit_error_flag_out(transmit_error_flag_out)
);
`default_nettype wire

// file: tb/txfe_host_model.sv
// host side of the transmit fifo: show-ahead queue filled by the bench
// assumes one pop pulse advances the head by the next edge
`timescale 1ns/10ps
`default_nettype none
module txfe_host_model (
  input wire logic clock_in,
  input wire logic stall_in,
  input wire logic pop_in,
  output logic [31:0] data_out,
  output logic valid_out
);
  logic [31:0] q[$];
  logic [31:0] last_word = 32'h0;
  initial begin
    data_out = 32'h0;
    valid_out = 1'b0;
  end
  // an empty or stalled head shows inverted stale data so nothing leans on it
  always @(posedge clock_in) begin
    if (pop_in && q.size() > 0)
      last_word = q.pop_front();
    #1;
    valid_out = q.size() > 0 && !stall_in;
    data_out = valid_out ? q[0] : ~last_word;
  end
endmodule
`default_nettype wire

// file: tb/test_txfe_extractor.sv
// bench for the frame extractor: random frames, options, faults
// assumes the host model on the fifo side and a random-ready sink
`timescale 1ns/10ps
`default_nettype none
module test_txfe_extractor;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] bus_addr_in = 4'h0;
  logic [31:0] bus_wdata_in = 32'h0;
  logic bus_write_in = 1'b0;
  logic bus_read_in = 1'b0;
  logic mac_ready_in = 1'b0;
  logic stall = 1'b0;
  wire logic [31:0] bus_rdata_out, fifo_data, mac_data_out;
  wire logic [3:0] mac_be_out;
  wire logic fifo_valid, fifo_pop, mac_valid_out, mac_last_out, csum, no_crc, no_pad, err;
  logic [7:0] exp_q[$], got_q[$];
  logic [31:0] d;
  int fail_count = 0;
  int n_compared = 0;
  int n_last = 0;
  always #5 clock_in = ~clock_in;
  txfe_extractor u_txfe_extractor (
    .clock_in(clock_in), .rst_in(rst_in), .bus_addr_in(bus_addr_in),
    .bus_wdata_in(bus_wdata_in), .bus_write_in(bus_write_in), .bus_read_in(bus_read_in),
    .bus_rdata_out(bus_rdata_out), .fifo_data_in(fifo_data), .fifo_valid_in(fifo_valid),
    .fifo_pop_out(fifo_pop), .mac_valid_out(mac_valid_out), .mac_data_out(mac_data_out),
    .mac_be_out(mac_be_out), .mac_last_out(mac_last_out), .mac_ready_in(mac_ready_in),
    .mac_csum_out(csum), .mac_no_crc_out(no_crc), .mac_no_pad_out(no_pad),
    .transmit_error_flag_out(err)
  );
  txfe_host_model u_txfe_host_model (
    .clock_in(clock_in), .stall_in(stall), .pop_in(fifo_pop),
    .data_out(fifo_data), .valid_out(fifo_valid)
  );
  always @(posedge clock_in) begin
    mac_ready_in <= ($urandom % 4) != 0;
    stall <= ($urandom % 5) == 0;
    if (mac_valid_out && mac_ready_in) begin
      for (int i = 0; i < 4; i++)
        if (mac_be_out[i]) got_q.push_back(mac_data_out[8*i+:8]);
      if (mac_last_out) n_last <= n_last + 1;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock_in);
    bus_write_in <= 1'b1;
    bus_addr_in <= a;
    bus_wdata_in <= v;
    @(posedge clock_in);
    bus_write_in <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clock_in);
    bus_read_in <= 1'b1;
    bus_addr_in <= a;
    @(posedge clock_in);
    bus_read_in <= 1'b0;
    #1 d = bus_rdata_out;
  endtask
  task do_reset;
    rst_in <= 1'b1;
    repeat (10) @(posedge clock_in);
    u_txfe_host_model.q.delete();
    exp_q.delete();
    got_q.delete();
    rst_in <= 1'b0;
  endtask
  // bad: 1 command b mismatch, 2 length over sizes, 3 first flag missing
  task send_frame(input int flen, input int nb, input logic [31:0] opt, input int bad);
    int sz, off, left;
    logic [31:0] a, b, w;
    logic [7:0] by;
    left = flen;
    for (int i = 0; i < nb; i++) begin
      sz = (i == nb - 1) ? left : flen / nb;
      left -= sz;
      off = $urandom % 4;
      a = {14'h0, off[1:0], 2'h0, i == 0 && bad != 3, i == nb - 1, 1'b0, sz[10:0]};
      b = opt | flen + (bad == 2 ? 4 : 0);
      if (i > 0) b[14] = $urandom;
      if (bad == 1 && i == 1) b[13] = ~b[13];
      u_txfe_host_model.q.push_back(a);
      u_txfe_host_model.q.push_back(b);
      for (int k = 0; k < (off + sz + 3) / 4 * 4; k++) begin
        by = $urandom;
        w[8*(k%4)+:8] = by;
        if (k >= off && k < off + sz && bad == 0) exp_q.push_back(by);
        if (k % 4 == 3) u_txfe_host_model.q.push_back(w);
      end
    end
  endtask
  task drain;
    int k;
    for (k = 0; k < 5000 && got_q.size() < exp_q.size(); k++)
      @(posedge clock_in);
    repeat (20) @(posedge clock_in);
    if (k == 5000) begin
      fail_count++;
      final_report();
    end
    check(got_q.size(), exp_q.size());
    foreach (exp_q[j]) if (j < got_q.size()) check(got_q[j], exp_q[j]);
    check(n_last, 1);
    n_last = 0;
    exp_q.delete();
    got_q.delete();
  endtask
  initial begin
    int flen, nb;
    logic [3:0] m;
    d = $urandom(2);
    do_reset();
    wr(4'h0, 32'h1);
    rd(4'h0);
    check(d, 32'h1);
    rd(4'h8);
    check(d, 32'h0);
    for (int i = 0; i < 16; i++) begin
      m = i;
      wr(4'h0, {31'h0, m[3]});
      flen = i == 0 ? 1 : i == 15 ? 2047 : 1 + $urandom % 300;
      nb = flen < 12 ? 1 : 1 + $urandom % 3;
      send_frame(flen, nb, {17'h0, m[2:0], 12'h0}, 0);
      drain();
      check(csum, m[2] & m[3]);
      check(no_crc, m[1] & ~m[0]);
      check(no_pad, m[0]);
      rd(4'h4);
      check(d[0], 1'b0);
      check(d[31:16], i + 1);
    end
    for (int e = 1; e < 4; e++) begin
      do_reset();
      send_frame(20, 2, 32'h0, e);
      repeat (150) @(posedge clock_in);
      check(err, 1'b1);
      rd(4'h4);
      check(d[0], 1'b1);
      check(d[1], 1'b1);
      repeat (20) @(posedge clock_in);
      check(err, 1'b1);
    end
    do_reset();
    final_report();
  end
endmodule
`default_nettype wire
